// ===== design/ssc_pkg.sv
`default_nettype none
package ssc_pkg;
	localparam int          ADDR_W        = 5;
	localparam int          DATA_W        = 32;
	localparam int          BYTE_W        = 8;
	localparam int          FIFO_DEPTH    = 4;

	// register byte offsets
	localparam logic [4:0]  OFF_CTRL      = 5'h00;
	localparam logic [4:0]  OFF_STATUS    = 5'h04;
	localparam logic [4:0]  OFF_TXDATA    = 5'h08;
	localparam logic [4:0]  OFF_RXDATA    = 5'h0C;

	// control register fields
	localparam int          CTRL_RUN      = 0;
	localparam int          CTRL_MODE_LSB = 1;
	localparam int          CTRL_ORDER    = 3;
	localparam int          CTRL_SEL_LSB  = 4;
	localparam int          CTRL_DIVSRC   = 7;
	localparam int          CTRL_LOWSPD   = 8;
	localparam int          CTRL_W        = 9;
	localparam logic [8:0]  CTRL_RESET    = 9'h000;

	// status register fields
	localparam int          STAT_ACTIVE   = 0;
	localparam int          STAT_TXEMPTY  = 1;
	localparam int          STAT_RXFULL   = 2;
	localparam int          STAT_MIDBYTE  = 3;
	localparam int          STAT_TXERR    = 4;
	localparam int          STAT_RXERR    = 5;

	// transfer mode codes
	localparam logic [1:0]  MODE_TX       = 2'h0;
	localparam logic [1:0]  MODE_RX       = 2'h1;
	localparam logic [1:0]  MODE_TXRX     = 2'h2;

	// clock select codes
	localparam logic [2:0]  SEL_SLOWEST   = 3'h0;
	localparam logic [2:0]  SEL_EXT       = 3'h7;

	// divider exponents and low-frequency half period
	localparam int          EXP_SLOWEST   = 12;
	localparam int          EXP_BASE      = 9;
	localparam int          FC_CNT_W      = 12;
	localparam logic [2:0]  LF_HALF_LAST  = 3'h7;

	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [7:0]  IDLE_BYTE     = 8'hFF;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT} ssc_state_t;
endpackage
`default_nettype wire

// ===== design/ssc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wrPtr_q;
	logic [PTR_W-1:0] rdPtr_q;
	logic [CNT_W-1:0] count_q;
	logic             push;
	logic             pop;

	function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
	endfunction

	assign inReady  = (count_q != CNT_W'(DEPTH));
	assign outValid = (count_q != '0);
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;
	assign outData  = mem[rdPtr_q];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= bump(wrPtr_q);
			end
			if (pop) begin
				rdPtr_q <= bump(rdPtr_q);
			end
			if (push & ~pop) begin
				count_q <= CNT_W'(count_q + 1'b1);
			end else if (pop & ~push) begin
				count_q <= CNT_W'(count_q - 1'b1);
			end
		end
	end
endmodule
`default_nettype wire

// ===== design/ssc_divider.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_divider (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic [2:0] clkSel,
	input  wire logic       divSrcOpt,
	input  wire logic       lowSpeed,
	input  wire logic       lfClkEn,
	output logic            halfTick
);
	import ssc_pkg::*;

	logic [FC_CNT_W-1:0] fcCnt_q;
	logic [2:0]          lfCnt_q;
	logic [FC_CNT_W-1:0] mask;
	logic                lfTick;

	// half period of fc/2^e is 2^(e-1) fast cycles
	function automatic logic [FC_CNT_W-1:0] halfMask(input logic [2:0] sel);
		int e;
		e = (sel == SEL_SLOWEST) ? EXP_SLOWEST : EXP_BASE - int'(sel);
		return FC_CNT_W'((1 << (e - 1)) - 1);
	endfunction

	assign mask   = halfMask(clkSel);
	assign lfTick = lfClkEn & (lfCnt_q == LF_HALF_LAST);

	always_comb begin
		if (clkSel == SEL_EXT) begin
			halfTick = 1'b0;
		end else if (lowSpeed) begin
			halfTick = (clkSel == SEL_SLOWEST) & lfTick;
		end else if ((clkSel == SEL_SLOWEST) & divSrcOpt) begin
			halfTick = lfTick;
		end else begin
			halfTick = ((fcCnt_q & mask) == mask);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fcCnt_q <= '0;
		end else begin
			fcCnt_q <= FC_CNT_W'(fcCnt_q + 1'b1);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lfCnt_q <= '0;
		end else if (lfClkEn) begin
			lfCnt_q <= 3'(lfCnt_q + 1'b1);
		end
	end
endmodule
`default_nettype wire

// ===== design/ssc_serial.sv
// Contract
// - select codes other than 111B drive divided clock out; 111B uses pin input
// - codes 001..110 give fc/2^8..fc/2^3; 000 gives fc/2^12 or fs/2^4
// - in low-speed or sleep modes only code 000 works, giving fs/2^4
// - internal clock pin idles high before and after a transfer
// - clock stops while transmit byte missing or received byte unread
// - after the stalling access, clock resumes within one serial period
// - outgoing bits change on the falling edge of the clock pin
// - incoming bits are sampled on the rising edge of the clock pin
// - bit order 0 sends bit 7 first, 1 sends bit 0 first
// - bit order 0 receives into bit 7 first, 1 into bit 0 first
// - one bit order setting serves transmit and receive alike
// - transfer flag reads 1 during a transfer, 0 once finished
// - mode 00B transmits, 01B receives, 10B does both
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module ssc_serial #(
	parameter int FIFO_DEPTH_P = ssc_pkg::FIFO_DEPTH
) (
	input  wire logic                        core_clk,
	input  wire logic                        sys_rst,
	input  wire logic [ssc_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [ssc_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ssc_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [ssc_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        lfClkEn,
	input  wire logic                        serialClkIn,
	output logic                             serialClkOut,
	output logic                             serialClkOe,
	output logic                             serialOut,
	input  wire logic                        serialIn
);
	import ssc_pkg::*;

	logic [CTRL_W-1:0]  ctrl_q;
	logic               txErr_q;
	logic               rxErr_q;
	logic [BYTE_W-1:0]  rxBuf_q;
	logic               rxFull_q;
	ssc_state_t         state_q;
	logic [2:0]         bitCnt_q;
	logic [BYTE_W-1:0]  txSh_q;
	logic [BYTE_W-1:0]  rxSh_q;
	logic               sclk_q;
	logic               sout_q;
	logic               extSync1_q;
	logic               extSync2_q;
	logic               extPrev_q;
	logic               awHeld_q;
	logic               wHeld_q;
	logic [ADDR_W-1:0]  awAddr_q;
	logic [DATA_W-1:0]  wData_q;
	logic [3:0]         wStrb_q;
	logic               bvalid_q;
	logic [1:0]         bresp_q;
	logic               rvalid_q;
	logic [DATA_W-1:0]  rdata_q;
	logic [1:0]         rresp_q;
	logic               runReq;
	logic [1:0]         mode;
	logic               lsbFirst;
	logic [2:0]         clkSel;
	logic               extMode;
	logic               txUsed;
	logic               rxUsed;
	logic               halfTick;
	logic               extFall;
	logic               extRise;
	logic               startOk;
	logic               fallEv;
	logic               riseEv;
	logic               beginByte;
	logic               byteDone;
	logic [BYTE_W-1:0]  txWord;
	logic [BYTE_W-1:0]  rxNext;
	logic               fifoInReady;
	logic               fifoOutValid;
	logic [BYTE_W-1:0]  fifoOutData;
	logic               fifoPop;
	logic               isTxWr;
	logic               doWrite;
	logic               wrHit;
	logic               rdTake;
	logic               rxPop;
	logic               statusWr;
	logic [DATA_W-1:0]  statusWord;

	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		return (a == OFF_CTRL) | (a == OFF_STATUS) |
			(a == OFF_TXDATA) | (a == OFF_RXDATA);
	endfunction
	// first bit out of a byte, honouring the bit order
	function automatic logic firstBit(input logic [BYTE_W-1:0] w,
			input logic lsb);
		return lsb ? w[0] : w[BYTE_W-1];
	endfunction
	// remainder after the first bit leaves; ones fill the vacancy
	function automatic logic [BYTE_W-1:0] restBits(
			input logic [BYTE_W-1:0] w, input logic lsb);
		return lsb ? {1'b1, w[BYTE_W-1:1]} : {w[BYTE_W-2:0], 1'b1};
	endfunction

	assign runReq   = ctrl_q[CTRL_RUN];
	assign mode     = ctrl_q[CTRL_MODE_LSB +: 2];
	assign lsbFirst = ctrl_q[CTRL_ORDER];
	assign clkSel   = ctrl_q[CTRL_SEL_LSB +: 3];
	assign extMode  = (clkSel == SEL_EXT);
	assign txUsed   = (mode == MODE_TX) | (mode == MODE_TXRX);
	assign rxUsed   = (mode == MODE_RX) | (mode == MODE_TXRX);
	ssc_divider u_divider (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.clkSel    (clkSel),
		.divSrcOpt (ctrl_q[CTRL_DIVSRC]),
		.lowSpeed  (ctrl_q[CTRL_LOWSPD]),
		.lfClkEn   (lfClkEn),
		.halfTick  (halfTick)
	);
	ssc_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH_P)
	) u_txfifo (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.inValid  (doWrite & isTxWr & wStrb_q[0]),
		.inReady  (fifoInReady),
		.inData   (wData_q[BYTE_W-1:0]),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOutData)
	);

	// external clock synchroniser and edge detect
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			extSync1_q <= 1'b1;
			extSync2_q <= 1'b1;
			extPrev_q  <= 1'b1;
		end else begin
			extSync1_q <= serialClkIn;
			extSync2_q <= extSync1_q;
			extPrev_q  <= extSync2_q;
		end
	end

	assign extFall = extMode & extPrev_q & ~extSync2_q;
	assign extRise = extMode & ~extPrev_q & extSync2_q;
	// with the internal clock, a new byte may start only with its data and buffer space at hand
	assign startOk = runReq & (~txUsed | fifoOutValid) &
		(~rxUsed | ~rxFull_q);
	always_comb begin
		if (extMode) begin
			fallEv = extFall & ((state_q == ST_RUN) | runReq);
			riseEv = extRise & (state_q == ST_RUN);
		end else begin
			fallEv = halfTick & sclk_q & ((state_q == ST_RUN) | startOk);
			riseEv = halfTick & ~sclk_q;
		end
	end
	assign beginByte = fallEv & (state_q != ST_RUN);
	assign byteDone  = riseEv & (bitCnt_q == 3'h7);
	assign fifoPop   = beginByte & txUsed & fifoOutValid;
	assign txWord    = (txUsed & fifoOutValid) ? fifoOutData : IDLE_BYTE;
	assign rxNext    = lsbFirst ? {serialIn, rxSh_q[BYTE_W-1:1]}
		: {rxSh_q[BYTE_W-2:0], serialIn};

	// transfer sequencing
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q  <= ST_IDLE;
			bitCnt_q <= '0;
		end else if (beginByte) begin
			state_q  <= ST_RUN;
			bitCnt_q <= '0;
		end else if (byteDone) begin
			state_q  <= runReq ? ST_WAIT : ST_IDLE;
			bitCnt_q <= '0;
		end else if (riseEv) begin
			bitCnt_q <= 3'(bitCnt_q + 1'b1);
		end else if ((state_q == ST_WAIT) & ~runReq) begin
			state_q  <= ST_IDLE;
		end
	end

	// clock pin: high when idle or waiting, driven only when internal
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_q <= 1'b1;
		end else if (extMode) begin
			sclk_q <= 1'b1;
		end else if (fallEv) begin
			sclk_q <= 1'b0;
		end else if (riseEv) begin
			sclk_q <= 1'b1;
		end
	end

	// transmit shifting on falling edges
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txSh_q <= IDLE_BYTE;
			sout_q <= 1'b1;
		end else if (beginByte) begin
			sout_q <= firstBit(txWord, lsbFirst);
			txSh_q <= restBits(txWord, lsbFirst);
		end else if (fallEv) begin
			sout_q <= firstBit(txSh_q, lsbFirst);
			txSh_q <= restBits(txSh_q, lsbFirst);
		end else if (byteDone & ~runReq) begin
			sout_q <= 1'b1;
		end
	end

	// receive shifting on rising edges
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxSh_q <= '0;
		end else if (riseEv) begin
			rxSh_q <= rxNext;
		end
	end
	// receive buffer; a same-cycle read wins over a byte completed while full
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxBuf_q  <= '0;
			rxFull_q <= 1'b0;
		end else if (byteDone & rxUsed & ~rxFull_q & ~rxErr_q) begin
			rxBuf_q  <= rxNext;
			rxFull_q <= 1'b1;
		end else if (rxPop) begin
			rxFull_q <= 1'b0;
		end
	end

	// error flags: set wins over a software clear
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txErr_q <= 1'b0;
			rxErr_q <= 1'b0;
		end else begin
			if (beginByte & extMode & txUsed & ~fifoOutValid) begin
				txErr_q <= 1'b1;
			end else if (statusWr & ~wData_q[STAT_TXERR]) begin
				txErr_q <= 1'b0;
			end
			if (byteDone & extMode & rxUsed & rxFull_q) begin
				rxErr_q <= 1'b1;
			end else if (statusWr & ~wData_q[STAT_RXERR]) begin
				rxErr_q <= 1'b0;
			end
		end
	end

	assign serialClkOut = sclk_q;
	assign serialClkOe  = ~extMode;
	assign serialOut    = sout_q;
	// write channel: address and data taken in either order
	assign isTxWr   = (awAddr_q == OFF_TXDATA);
	assign wrHit    = awHeld_q & wHeld_q & ~bvalid_q;
	assign doWrite  = wrHit & (~isTxWr | ~wStrb_q[0] | fifoInReady);
	assign statusWr = doWrite & (awAddr_q == OFF_STATUS) & wStrb_q[0];
	assign s_axi_awready = ~awHeld_q & ~bvalid_q;
	assign s_axi_wready  = ~wHeld_q & ~bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awAddr_q <= '0;
			wData_q  <= '0;
			wStrb_q  <= '0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
			end else if (doWrite) begin
				awHeld_q <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid_q <= 1'b1;
			bresp_q  <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	// control register, byte lanes applied
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RESET;
		end else if (doWrite & (awAddr_q == OFF_CTRL)) begin
			if (wStrb_q[0]) begin
				ctrl_q[7:0] <= wData_q[7:0];
			end
			if (wStrb_q[1]) begin
				ctrl_q[CTRL_W-1:8] <= wData_q[CTRL_W-1:8];
			end
		end
	end

	// read channel; reading received data frees the buffer
	assign rdTake = s_axi_arvalid & s_axi_arready;
	assign rxPop  = rdTake & ({s_axi_araddr[ADDR_W-1:2], 2'b00} == OFF_RXDATA);
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	always_comb begin
		statusWord               = '0;
		statusWord[STAT_ACTIVE]  = (state_q != ST_IDLE);
		statusWord[STAT_TXEMPTY] = ~fifoOutValid;
		statusWord[STAT_RXFULL]  = rxFull_q;
		statusWord[STAT_MIDBYTE] = (state_q == ST_RUN);
		statusWord[STAT_TXERR]   = txErr_q;
		statusWord[STAT_RXERR]   = rxErr_q;
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (rdTake) begin
			rvalid_q <= 1'b1;
			rresp_q  <= RESP_OKAY;
			unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				OFF_CTRL:   rdata_q <= DATA_W'(ctrl_q);
				OFF_STATUS: rdata_q <= statusWord;
				OFF_RXDATA: rdata_q <= DATA_W'(rxBuf_q);
				OFF_TXDATA: rdata_q <= '0;
				default: begin
					rdata_q <= '0;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== verif/ssc_serial_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_serial_monitor (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        serialClkOut,
	input wire logic        serialClkOe,
	input wire logic        serialOut
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_fallDriven;
		serialClkOe && $fell(serialClkOut);
	endsequence
	sequence s_lowPhase;
		!serialClkOut [*4];
	endsequence
	sequence s_highPhase;
		serialClkOut [*4];
	endsequence

	property p_rstIdle;
		$fell(sys_rst) |-> serialClkOut && serialOut && serialClkOe;
	endproperty
	property p_lowMin;
		s_fallDriven |-> s_lowPhase;
	endproperty
	property p_highMin;
		serialClkOe && $rose(serialClkOut) |-> s_highPhase;
	endproperty
	property p_dataHold;
		s_fallDriven |-> ##2 $stable(serialOut) [*2];
	endproperty
	property p_rNext;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_arBlock;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_bBlock;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_bDone;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	property p_rDone;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty

	a_rstIdle: assert property (p_rstIdle)
		else $error("pins not idle after reset");
	a_lowMin: assert property (p_lowMin)
		else $error("clock low phase too short");
	a_highMin: assert property (p_highMin)
		else $error("clock high phase too short");
	a_dataHold: assert property (p_dataHold)
		else $error("data moved inside low phase");
	a_rNext: assert property (p_rNext)
		else $error("read answer late");
	a_arBlock: assert property (p_arBlock)
		else $error("read address open during answer");
	a_bBlock: assert property (p_bBlock)
		else $error("write open during answer");
	a_bDone: assert property (p_bDone)
		else $error("write answer not released");
	a_rDone: assert property (p_rDone)
		else $error("read answer not released");
endmodule
bind ssc_serial ssc_serial_monitor uMon (.core_clk, .sys_rst, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .serialClkOut, .serialClkOe, .serialOut);
`default_nettype wire

// ===== verif/ssc_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_peer_model (
	input  wire logic       core_clk,
	input  wire logic       sclkPin,
	input  wire logic       sdo,
	input  wire logic       lsbFirst,
	input  wire logic [7:0] sendByte,
	output logic            sdi,
	output logic            extClk,
	output logic [7:0]      gotByte,
	output logic [7:0]      riseCnt
);
	logic [7:0] shiftOut;
	logic [2:0] fallCnt;
	initial begin
		sdi = 1'b1;
		extClk = 1'b1;
		gotByte = 8'h00;
		riseCnt = 8'h00;
		fallCnt = 3'h0;
		shiftOut = 8'h00;
	end
	always @(negedge sclkPin) begin
		if (fallCnt == 3'h0)
			shiftOut = sendByte;
		sdi <= lsbFirst ? shiftOut[fallCnt] : shiftOut[3'h7 - fallCnt];
		fallCnt <= fallCnt + 3'h1;
	end
	always @(posedge sclkPin) begin
		gotByte <= lsbFirst ? {sdo, gotByte[7:1]} : {gotByte[6:0], sdo};
		riseCnt <= riseCnt + 8'h01;
	end
	// one byte of external clock; half must stay at four or more
	task automatic clockByte(input int half);
		repeat (8) begin
			@(posedge core_clk);
			extClk <= 1'b0;
			repeat (half) @(posedge core_clk);
			extClk <= 1'b1;
			repeat (half - 1) @(posedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

// ===== verif/ssc_serial_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_serial_tb;
	import ssc_pkg::*;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [4:0]  awaddr = 5'h00;
	logic [4:0]  araddr = 5'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        arvalid = 1'b0;
	logic        lfClkEn = 1'b0;
	logic [1:0]  lfCnt = 2'h0;
	logic        lsbFirst = 1'b0;
	logic [7:0]  sendByte = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        sclkOut, sclkOe, sdo, sdi, extClk, pin;
	logic [1:0]  bresp, rresp, rsp;
	logic [31:0] rdata, rdv;
	logic [7:0]  gotByte, riseCnt, n;
	time         tPrev, tLast, t0;
	int          err_total = 0;
	int          cmp_count = 0;

	always #20 core_clk = ~core_clk;
	assign pin = sclkOe ? sclkOut : extClk;
	always @(posedge core_clk) begin
		lfCnt <= lfCnt + 2'h1;
		lfClkEn <= (lfCnt == 2'h3);
	end
	always @(negedge pin) begin
		tPrev = tLast;
		tLast = $time;
	end

	ssc_serial uut (.core_clk, .sys_rst, .lfClkEn,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .serialClkIn(extClk),
		.serialClkOut(sclkOut), .serialClkOe(sclkOe), .serialOut(sdo),
		.serialIn(sdi));
	ssc_peer_model uPeer (.core_clk, .sclkPin(pin), .sdo, .lsbFirst, .sendByte,
		.sdi, .extClk, .gotByte, .riseCnt);

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic axw(input logic [4:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		rsp = bresp;
	endtask
	task automatic axr(input logic [4:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rdv = rdata;
		rsp = rresp;
	endtask
	function automatic logic [31:0] ctl(input logic run, input logic [1:0] md,
		input logic ord, input logic [2:0] sel, input logic dv, input logic lo);
		return {23'h0, lo, dv, sel, ord, md, run};
	endfunction
	task automatic waitRises(input logic [7:0] k);
		logic [7:0] base;
		base = riseCnt;
		while (8'(riseCnt - base) != k)
			@(posedge core_clk);
	endtask
	task automatic stop(input logic [31:0] c);
		axw(OFF_CTRL, c);
		do
			axr(OFF_STATUS);
		while (rdv[STAT_ACTIVE] !== 1'b0);
	endtask

	task automatic t_reset();
		check({sclkOut, sclkOe, sdo}, 3'h7);
		axr(OFF_CTRL);
		check(rdv, 32'h0000_0000);
		axr(OFF_STATUS);
		check(rdv, 32'h0000_0002);
		axr(5'h10);
		check({rsp, rdv}, {RESP_SLVERR, 32'h0000_0000});
		axw(5'h14, 32'hFFFF_FFFF);
		check(rsp, RESP_SLVERR);
		$display("test reset done");
	endtask
	task automatic t_rates();
		logic [7:0] tx;
		for (int s = 0; s <= 6; s++) begin
			tx = 8'h35 + 8'(s * 29);
			lsbFirst <= s[0];
			sendByte <= 8'hC9 - 8'(s * 13);
			axw(OFF_CTRL, ctl(1'b0, MODE_TXRX, s[0], 3'(s), 1'b0, 1'b0));
			axw(OFF_TXDATA, {24'h0, tx});
			axw(OFF_CTRL, ctl(1'b1, MODE_TXRX, s[0], 3'(s), 1'b0, 1'b0));
			waitRises(8'h08);
			check(34'((tLast - tPrev) / 40), 34'(1) << (s ? 9 - s : 12));
			check(gotByte, tx);
			axr(OFF_RXDATA);
			check(rdv[7:0], sendByte);
			axr(OFF_STATUS);
			check(rdv[3:0], 4'h3);
			stop(ctl(1'b0, MODE_TXRX, s[0], 3'(s), 1'b0, 1'b0));
		end
		$display("test rates and order done");
	endtask
	task automatic t_fifo();
		axw(OFF_CTRL, ctl(1'b0, MODE_TX, 1'b0, 3'h6, 1'b0, 1'b0));
		lsbFirst <= 1'b0;
		for (int i = 0; i < 4; i++)
			axw(OFF_TXDATA, 32'h0000_0010 + 32'(i));
		axr(OFF_STATUS);
		check(rdv[STAT_TXEMPTY], 1'b0);
		axw(OFF_CTRL, ctl(1'b1, MODE_TX, 1'b0, 3'h6, 1'b0, 1'b0));
		axw(OFF_TXDATA, 32'h0000_005A);
		waitRises(8'h28);
		check(gotByte, 8'h5A);
		n = riseCnt;
		repeat (100) @(posedge core_clk);
		check({riseCnt, pin}, {n, 1'b1});
		t0 = $time;
		axw(OFF_TXDATA, 32'h0000_0096);
		wait (tLast > t0);
		check(34'(((tLast - t0) / 40) <= 11), 34'h1);
		waitRises(8'h08);
		check(gotByte, 8'h96);
		stop(ctl(1'b0, MODE_TX, 1'b0, 3'h6, 1'b0, 1'b0));
		$display("test fifo and wait done");
	endtask
	task automatic t_ext();
		axw(OFF_CTRL, ctl(1'b0, MODE_TXRX, 1'b1, SEL_EXT, 1'b0, 1'b0));
		check(sclkOe, 1'b0);
		lsbFirst <= 1'b1;
		sendByte <= 8'h3B;
		axw(OFF_TXDATA, 32'h0000_00C6);
		axw(OFF_CTRL, ctl(1'b1, MODE_TXRX, 1'b1, SEL_EXT, 1'b0, 1'b0));
		uPeer.clockByte(6);
		repeat (8) @(posedge core_clk);
		check(gotByte, 8'hC6);
		uPeer.clockByte(6);
		repeat (8) @(posedge core_clk);
		check(gotByte, 8'hFF);
		axr(OFF_STATUS);
		check(rdv[STAT_RXERR:STAT_TXERR], 2'h3);
		axw(OFF_STATUS, 32'h0000_0000);
		check(rsp, RESP_OKAY);
		axr(OFF_STATUS);
		check(rdv[STAT_RXERR:STAT_TXERR], 2'h0);
		stop(ctl(1'b0, MODE_TXRX, 1'b1, SEL_EXT, 1'b0, 1'b0));
		axr(OFF_RXDATA);
		check(rdv[7:0], 8'h3B);
		$display("test external clock done");
	endtask
	task automatic t_low();
		for (int k = 0; k < 2; k++) begin
			lsbFirst <= 1'b0;
			sendByte <= 8'h4D;
			axw(OFF_CTRL, ctl(1'b0, 2'(k), 1'b0, SEL_SLOWEST, !k[0], k[0]));
			if (k == 0)
				axw(OFF_TXDATA, 32'h0000_00E1);
			axw(OFF_CTRL, ctl(1'b1, 2'(k), 1'b0, SEL_SLOWEST, !k[0], k[0]));
			waitRises(8'h08);
			check(34'((tLast - tPrev) / 40), 34'h40);
			stop(ctl(1'b0, 2'(k), 1'b0, SEL_SLOWEST, !k[0], k[0]));
			axr(OFF_RXDATA);
			check(k ? rdv[7:0] : gotByte, k ? 8'h4D : 8'hE1);
		end
		axw(OFF_CTRL, ctl(1'b0, MODE_TX, 1'b0, 3'h2, 1'b0, 1'b1));
		axw(OFF_TXDATA, 32'h0000_0077);
		axw(OFF_CTRL, ctl(1'b1, MODE_TX, 1'b0, 3'h2, 1'b0, 1'b1));
		n = riseCnt;
		repeat (300) @(posedge core_clk);
		check({riseCnt, pin}, {n, 1'b1});
		$display("test low frequency done");
	endtask

	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge core_clk);
		err_total++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_rates();
		t_fifo();
		t_ext();
		t_low();
		end_of_test();
	end
endmodule
`default_nettype wire
